// file: rtl/usart_pkg.sv
package usart_pkg;

  // Register byte offsets on the APB slave.
  localparam logic [7:0] OFF_MAIN = 8'h00;
  localparam logic [7:0] OFF_RXCTL = 8'h04;
  localparam logic [7:0] OFF_IRQCLK = 8'h08;
  localparam logic [7:0] OFF_TXBUF = 8'h0c;
  localparam logic [7:0] OFF_RXBUF = 8'h10;
  localparam logic [7:0] OFF_DIVLO = 8'h14;
  localparam logic [7:0] OFF_PRESC = 8'h18;
  localparam logic [7:0] OFF_PINCTL = 8'h1c;

  // Oversampling timing in 16x ticks: full bit, half bit, seven eighths of a bit.
  localparam logic [3:0] SUB_LAST = 4'hf;
  localparam logic [3:0] SUB_HALF = 4'h7;
  localparam logic [3:0] SUB_SHORT = 4'hd;

  // Receive shift register width; the longest payload (data plus parity or ninth bit) is nine bits.
  localparam logic [3:0] RX_SHIFT_W = 4'ha;

  // Values after reset.
  localparam logic TX_EMPTY_RST = 1'b1;
  localparam logic [12:0] TX_SHIFT_RST = 13'h1fff;
  localparam logic [4:0] PRESC_RST = 5'h00;

  // Frame layout, bits 7:3 of the main control and status register.
  typedef struct packed {
    logic parity_enable;
    logic parity_type_sel1;
    logic tx_ninth_bit;
    logic frame_len_sel1;
    logic frame_len_sel0;
  } frame_cfg_t;

  // Interrupt enable and clock source register, bit 7 down to bit 0.
  typedef struct packed {
    logic stop2;
    logic stop78;
    logic tx_pin_enable;
    logic sync_mode_select;
    logic rx_clk_ext;
    logic tx_clk_ext;
    logic rx_irq_enable;
    logic tx_irq_enable;
  } irq_clk_cfg_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } apb_rsp_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_SHIFT = 2'b10
  } tx_state_t;

  typedef enum logic [2:0] {
    RX_IDLE = 3'b001,
    RX_START = 3'b010,
    RX_DATA = 3'b100
  } rx_state_t;

endpackage

// file: rtl/usart_core.sv
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Async uses 16x clock, sync uses 1x.
// - Frame end reloads shift; each buffer load sets empty flag.
// - Holding buffer write clears empty flag.
// - Active flag high until last stop ends.
// - Start low rechecked at half bit, mid-bit sampling.
// - Complete char to holding buffer, read clears.
// - Break flag on framing error, clears high.
// - Sync: launch on rising, capture on falling.
// - Clock pin input or driven from generator.
// - Seven data bits plus optional parity.
// - Eight data bits plus optional parity.
// - Nine data bits, ninth from register, no parity.
// - One or two stops, last optionally seven eighths.
// - Parity only for 7/8 bits when enabled.
// - Receiver needs only a single stop bit.
// - Tx interrupt pends while empty and enabled.
// - Rx interrupt pends while full and enabled.
// - Separate rx and tx interrupt vectors.
// - Tx and rx clock sources chosen independently.
// - Divisor upper bits live in prescaler register.
// - Prescaler code zero stops the clock.
// - Code k divides oscillator by (k+1)/2.
// - Async 16x clock divided by sixteen.
// - Divisor field holds N minus one.
// - Both selects set loop tx into rx.
module usart_core (
  input wire logic mclk,
  input wire logic rstn,
  input wire usart_pkg::apb_req_t apb_req,
  output usart_pkg::apb_rsp_t apb_rsp,
  input wire logic serial_rx_pin,
  output logic serial_tx_pin,
  input wire logic serial_clock_pin,
  output logic serial_clock_out,
  output logic serial_clock_oe,
  output logic tx_irq,
  output logic rx_irq
);
  import usart_pkg::*;

  typedef struct packed {
    apb_rsp_t rsp;
    frame_cfg_t frame_cfg;
    irq_clk_cfg_t irq_clk;
    logic rx_spare;
    logic clock_pin_drive;
    logic [7:0] tx_holding_buf;
    logic [7:0] rx_holding_buf;
    logic [4:0] presc;
    logic [10:0] divisor;
    logic [5:0] pre_acc;
    logic [10:0] baud_cnt;
    logic gen_clk;
    logic rx_meta;
    logic rx_sync;
    logic ck_meta;
    logic ck_sync;
    logic ck_prev;
    tx_state_t tx_state;
    logic [12:0] tx_shift_reg;
    logic [3:0] tx_left;
    logic [3:0] tx_sub;
    logic tx_buf_empty_flag;
    logic tx_active_flag;
    logic serial_tx;
    rx_state_t rx_state;
    logic [9:0] rx_shift_reg;
    logic [3:0] rx_cnt;
    logic [3:0] rx_sub;
    logic rx_buf_full_flag;
    logic rx_ninth_bit;
    logic rx_break_flag;
    logic overrun_err;
    logic framing_err;
    logic parity_err;
    logic tx_irq;
    logic rx_irq;
  } state_t;

  state_t s;
  state_t next_s;

  logic acc;
  logic done;
  logic hit;
  logic wr;
  logic rd;
  logic [7:0] rd_byte;
  logic [5:0] step;
  logic [5:0] lim;
  logic gen_tick;
  logic gen_rise;
  logic gen_fall;
  logic ext_rise;
  logic ext_fall;
  logic sync;
  logic nine;
  logic loopback;
  logic par_on;
  logic [3:0] nd;
  logic [3:0] nb_pre;
  logic tx_step;
  logic rx_step;
  logic tx_wr_now;
  logic tx_can_load;
  logic tx_last;
  logic sub_end;
  logic rx_in;
  logic [9:0] aligned;
  logic [7:0] rx_data;

  // Parity over seven or eight data bits: 00 odd, 01 even, 10 mark, 11 space.
  function automatic logic parity_of(input logic [7:0] d, input logic seven,
                                     input logic sel1, input logic sel0);
    logic ones;
    ones = seven ? ^d[6:0] : ^d;
    case ({sel1, sel0})
      2'b00: parity_of = ~ones;
      2'b01: parity_of = ones;
      2'b10: parity_of = 1'b1;
      default: parity_of = 1'b0;
    endcase
  endfunction

  // Combinational next state of the whole block.
  always_comb begin
    next_s = s;
    // Two-stage synchronisers; the edge detector reads only the second stage onward.
    next_s.rx_meta = serial_rx_pin;
    next_s.rx_sync = s.rx_meta;
    next_s.ck_meta = serial_clock_pin;
    next_s.ck_sync = s.ck_meta;
    next_s.ck_prev = s.ck_sync;
    ext_rise = s.ck_sync & ~s.ck_prev;
    ext_fall = ~s.ck_sync & s.ck_prev;

    sync = s.irq_clk.sync_mode_select;
    nine = s.frame_cfg.frame_len_sel1;
    loopback = s.frame_cfg.frame_len_sel1 & s.frame_cfg.frame_len_sel0;
    par_on = s.frame_cfg.parity_enable & ~nine;
    nd = nine ? 4'h9 : (s.frame_cfg.frame_len_sel0 ? 4'h7 : 4'h8);
    nb_pre = nd + {3'h0, par_on};

    // APB slave: one wait state, then pready for exactly one cycle.
    acc = apb_req.psel & apb_req.penable;
    done = acc & s.rsp.pready;
    hit = (apb_req.paddr[1:0] == 2'b00) && (apb_req.paddr <= OFF_PINCTL);
    wr = done & apb_req.pwrite & hit;
    rd = done & ~apb_req.pwrite & hit;
    case (apb_req.paddr)
      OFF_MAIN: rd_byte = {s.frame_cfg, s.overrun_err | s.framing_err | s.parity_err,
                           s.rx_buf_full_flag, s.tx_buf_empty_flag};
      OFF_RXCTL: rd_byte = {s.overrun_err, s.framing_err, s.parity_err, s.rx_spare,
                            s.rx_ninth_bit, 1'b0, s.tx_active_flag, s.rx_break_flag};
      OFF_IRQCLK: rd_byte = s.irq_clk;
      OFF_TXBUF: rd_byte = s.tx_holding_buf;
      OFF_RXBUF: rd_byte = s.rx_holding_buf;
      OFF_DIVLO: rd_byte = s.divisor[7:0];
      OFF_PRESC: rd_byte = {s.presc, s.divisor[10:8]};
      OFF_PINCTL: rd_byte = {7'h00, s.clock_pin_drive};
      default: rd_byte = 8'h00;
    endcase
    next_s.rsp.pready = acc & ~s.rsp.pready;
    if (acc & ~s.rsp.pready) begin
      next_s.rsp.prdata = {24'h000000, rd_byte};
      next_s.rsp.pslverr = ~hit;
    end

    // Register writes. The receive holding buffer and status flags ignore writes.
    tx_wr_now = wr && (apb_req.paddr == OFF_TXBUF);
    if (wr) begin
      case (apb_req.paddr)
        OFF_MAIN: next_s.frame_cfg = apb_req.pwdata[7:3];
        OFF_RXCTL: next_s.rx_spare = apb_req.pwdata[4];
        OFF_IRQCLK: next_s.irq_clk = apb_req.pwdata[7:0];
        OFF_TXBUF: begin
          next_s.tx_holding_buf = apb_req.pwdata[7:0];
          next_s.tx_buf_empty_flag = 1'b0;
        end
        OFF_DIVLO: next_s.divisor[7:0] = apb_req.pwdata[7:0];
        OFF_PRESC: begin
          next_s.presc = apb_req.pwdata[7:3];
          next_s.divisor[10:8] = apb_req.pwdata[2:0];
        end
        OFF_PINCTL: next_s.clock_pin_drive = apb_req.pwdata[0];
        default: next_s.clock_pin_drive = s.clock_pin_drive;
      endcase
    end
    // Read side effects; hardware sets further down win over these clears.
    if (rd && (apb_req.paddr == OFF_RXBUF)) begin
      next_s.rx_buf_full_flag = 1'b0;
    end
    if (rd && (apb_req.paddr == OFF_RXCTL)) begin
      next_s.overrun_err = 1'b0;
      next_s.framing_err = 1'b0;
      next_s.parity_err = 1'b0;
    end

    // Baud generator: half-step prescaler by accumulating two per cycle against k+1,
    // then the divisor counter. The accumulator trades a little jitter for no 2x clock.
    gen_tick = 1'b0;
    step = s.pre_acc + 6'd2;
    lim = {1'b0, s.presc} + 6'd1;
    if (s.presc == 5'h00) begin
      next_s.pre_acc = 6'd0;
      next_s.baud_cnt = 11'h000;
    end else if (step >= lim) begin
      next_s.pre_acc = step - lim;
      if (s.baud_cnt >= s.divisor) begin
        next_s.baud_cnt = 11'h000;
        gen_tick = 1'b1;
      end else begin
        next_s.baud_cnt = s.baud_cnt + 11'd1;
      end
    end else begin
      next_s.pre_acc = step;
    end
    // In sync mode two generator ticks make one serial clock period.
    if (gen_tick) begin
      next_s.gen_clk = ~s.gen_clk;
    end
    gen_rise = gen_tick & ~s.gen_clk;
    gen_fall = gen_tick & s.gen_clk;

    // Independent clock source per direction; sync steps on edges, async on 16x ticks.
    tx_step = s.irq_clk.tx_clk_ext ? ext_rise : (sync ? gen_rise : gen_tick);
    rx_step = s.irq_clk.rx_clk_ext ? (sync ? ext_fall : ext_rise)
                                   : (sync ? gen_fall : gen_tick);

    // Transmitter. A load is held off in the cycle software writes the buffer.
    tx_can_load = ~s.tx_buf_empty_flag & ~tx_wr_now;
    tx_last = (s.tx_left == 4'h1);
    sub_end = sync | (s.tx_sub == ((tx_last & s.irq_clk.stop78) ? SUB_SHORT : SUB_LAST));
    case (s.tx_state)
      TX_IDLE: begin
        if (tx_can_load & tx_step) begin
          next_s.tx_state = TX_SHIFT;
        end
      end
      TX_SHIFT: begin
        if (tx_step) begin
          if (sub_end) begin
            next_s.tx_sub = 4'h0;
            if (tx_last & ~tx_can_load) begin
              next_s.tx_state = TX_IDLE;
              next_s.tx_active_flag = 1'b0;
              next_s.tx_shift_reg = TX_SHIFT_RST;
            end else if (~tx_last) begin
              next_s.tx_shift_reg = {1'b1, s.tx_shift_reg[12:1]};
              next_s.tx_left = s.tx_left - 4'h1;
            end
          end else begin
            next_s.tx_sub = s.tx_sub + 4'h1;
          end
        end
      end
      default: next_s.tx_state = TX_IDLE;
    endcase
    // Load holding buffer into the shift register: idle start or back to back.
    if (tx_can_load & tx_step & ((s.tx_state == TX_IDLE) | (tx_last & sub_end))) begin
      next_s.tx_state = TX_SHIFT;
      next_s.tx_sub = 4'h0;
      next_s.tx_active_flag = 1'b1;
      next_s.tx_buf_empty_flag = 1'b1;
      next_s.tx_left = nb_pre + 4'h2 + {3'h0, s.irq_clk.stop2};
      if (nine) begin
        next_s.tx_shift_reg = {3'h7, s.frame_cfg.tx_ninth_bit, s.tx_holding_buf, 1'b0};
      end else if (nd == 4'h7) begin
        next_s.tx_shift_reg = {4'hf, par_on ? parity_of(s.tx_holding_buf, 1'b1,
                               s.frame_cfg.parity_type_sel1, s.frame_cfg.tx_ninth_bit) : 1'b1,
                               s.tx_holding_buf[6:0], 1'b0};
      end else begin
        next_s.tx_shift_reg = {3'h7, par_on ? parity_of(s.tx_holding_buf, 1'b0,
                               s.frame_cfg.parity_type_sel1, s.frame_cfg.tx_ninth_bit) : 1'b1,
                               s.tx_holding_buf, 1'b0};
      end
    end
    // In loopback the pin idles at mark while the line goes inside.
    next_s.serial_tx = (s.irq_clk.tx_pin_enable & ~loopback) ? next_s.tx_shift_reg[0] : 1'b1;

    // Receiver.
    rx_in = loopback ? s.tx_shift_reg[0] : s.rx_sync;
    if (rx_in) begin
      next_s.rx_break_flag = 1'b0;
    end
    aligned = s.rx_shift_reg >> (RX_SHIFT_W - nb_pre);
    rx_data = (nd == 4'h7) ? {1'b0, aligned[6:0]} : aligned[7:0];
    case (s.rx_state)
      RX_IDLE: begin
        if (rx_step & ~rx_in) begin
          next_s.rx_state = sync ? RX_DATA : RX_START;
          next_s.rx_sub = 4'h0;
          next_s.rx_cnt = 4'h0;
        end
      end
      RX_START: begin
        if (rx_step) begin
          if (s.rx_sub == SUB_HALF) begin
            next_s.rx_state = rx_in ? RX_IDLE : RX_DATA;
            next_s.rx_sub = 4'h0;
          end else begin
            next_s.rx_sub = s.rx_sub + 4'h1;
          end
        end
      end
      RX_DATA: begin
        if (rx_step) begin
          if (sync | (s.rx_sub == SUB_LAST)) begin
            next_s.rx_sub = 4'h0;
            if (s.rx_cnt == nb_pre) begin
              // Only one stop bit is checked, whatever the transmit setting.
              next_s.rx_state = RX_IDLE;
              next_s.rx_holding_buf = rx_data;
              next_s.overrun_err = next_s.overrun_err | next_s.rx_buf_full_flag;
              next_s.rx_buf_full_flag = 1'b1;
              if (nine) begin
                next_s.rx_ninth_bit = aligned[8];
              end
              if (~rx_in) begin
                next_s.framing_err = 1'b1;
                next_s.rx_break_flag = 1'b1;
              end
              if (par_on && (aligned[nd] != parity_of(aligned[7:0], nd == 4'h7,
                  s.frame_cfg.parity_type_sel1, s.frame_cfg.tx_ninth_bit))) begin
                next_s.parity_err = 1'b1;
              end
            end else begin
              next_s.rx_shift_reg = {rx_in, s.rx_shift_reg[9:1]};
              next_s.rx_cnt = s.rx_cnt + 4'h1;
            end
          end else begin
            next_s.rx_sub = s.rx_sub + 4'h1;
          end
        end
      end
      default: next_s.rx_state = RX_IDLE;
    endcase

    // Level-pending requests; each feeds its own vector in the interrupt controller.
    next_s.tx_irq = next_s.tx_buf_empty_flag & next_s.irq_clk.tx_irq_enable;
    next_s.rx_irq = next_s.rx_buf_full_flag & next_s.irq_clk.rx_irq_enable;
  end

  // Single state register; reset loads constants only.
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      s <= '0;
      s.presc <= PRESC_RST;
      s.tx_buf_empty_flag <= TX_EMPTY_RST;
      s.tx_shift_reg <= TX_SHIFT_RST;
      s.serial_tx <= 1'b1;
      s.tx_state <= TX_IDLE;
      s.rx_state <= RX_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // Every output is a field of the state register.
  assign apb_rsp = s.rsp;
  assign serial_tx_pin = s.serial_tx;
  assign serial_clock_out = s.gen_clk;
  assign serial_clock_oe = s.clock_pin_drive;
  assign tx_irq = s.tx_irq;
  assign rx_irq = s.rx_irq;

endmodule

`default_nettype wire

// file: tb/usart_core_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module usart_core_asserts (
  input wire logic mclk,
  input wire logic rstn,
  input wire usart_pkg::apb_req_t apb_req,
  input wire usart_pkg::apb_rsp_t apb_rsp,
  input wire logic serial_rx_pin,
  input wire logic serial_tx_pin,
  input wire logic serial_clock_pin,
  input wire logic serial_clock_out,
  input wire logic serial_clock_oe,
  input wire logic tx_irq,
  input wire logic rx_irq
);
  import usart_pkg::*;
  logic [7:0] low_run;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  // Counts low cycles on the line; the bench keeps one clock per oversampling tick.
  always_ff @(posedge mclk) begin
    if (!rstn || serial_tx_pin) begin
      low_run <= 8'h00;
    end else begin
      low_run <= low_run + 8'h01;
    end
  end
  // Bus answer timing and response fields.
  chk_one_wait: assert property ((apb_req.psel && !apb_req.penable) |=>
    !apb_rsp.pready ##1 apb_rsp.pready) else $error("apb wait state wrong");
  chk_ready_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("pready longer than one cycle");
  chk_ready_req: assert property (apb_rsp.pready |-> apb_req.psel && apb_req.penable)
    else $error("pready without access phase");
  chk_slverr_map: assert property (apb_rsp.pready |-> apb_rsp.pslverr ==
    (apb_req.paddr[1:0] != 2'b00 || apb_req.paddr > OFF_PINCTL)) else $error("pslverr wrong");
  chk_rdata_upper: assert property (apb_rsp.pready |-> apb_rsp.prdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  // Interrupt levels drop at the edge after the clearing access; a reload may raise them later.
  chk_tx_irq_clear: assert property ((apb_rsp.pready && apb_req.pwrite &&
    apb_req.paddr == OFF_TXBUF) |=> !tx_irq) else $error("tx irq stuck after write");
  chk_rx_irq_clear: assert property ((apb_rsp.pready && !apb_req.pwrite &&
    apb_req.paddr == OFF_RXBUF) |=> !rx_irq) else $error("rx irq stuck after read");
  chk_reset_idle: assert property ($rose(rstn) |-> serial_tx_pin && !tx_irq &&
    !rx_irq && !serial_clock_oe && !serial_clock_out) else $error("outputs not idle");
  chk_bit_multiple: assert property ($rose(serial_tx_pin) |-> low_run[3:0] == 4'h0)
    else $error("low stretch not whole bits");
  cov_tx_write: cover property (apb_rsp.pready && apb_req.pwrite && apb_req.paddr == OFF_TXBUF);
  cov_rx_irq: cover property ($rose(rx_irq));
  cov_slverr: cover property (apb_rsp.pready && apb_rsp.pslverr);
endmodule
bind usart_core usart_core_asserts i_usart_core_asserts (.mclk(mclk), .rstn(rstn),
  .apb_req(apb_req), .apb_rsp(apb_rsp), .serial_rx_pin(serial_rx_pin),
  .serial_tx_pin(serial_tx_pin), .serial_clock_pin(serial_clock_pin),
  .serial_clock_out(serial_clock_out), .serial_clock_oe(serial_clock_oe),
  .tx_irq(tx_irq), .rx_irq(rx_irq));
`default_nettype wire

// file: tb/usart_partner.sv
`timescale 1ns/1ps
`default_nettype none
module usart_partner (
  input wire logic mclk,
  input wire logic line_in,
  output logic line_out,
  output logic clk_out
);
  logic [8:0] rxq[$];
  int nbits;
  // The station runs asynchronously, so its clock output stands still.
  initial begin
    line_out = 1'b1;
    clk_out = 1'b0;
    nbits = 8;
  end
  // Sends a start bit, n bits low first, then a single stop bit of the given level.
  task automatic send(input logic [8:0] d, input int n, input logic stop_v);
    line_out <= 1'b0;
    repeat (16) @(posedge mclk);
    for (int i = 0; i < n; i++) begin
      line_out <= d[i];
      repeat (16) @(posedge mclk);
    end
    line_out <= stop_v;
    repeat (16) @(posedge mclk);
    line_out <= 1'b1;
  endtask
  // Receives frames, rechecking the start half a bit in; a bad stop drops the frame.
  initial begin
    logic [8:0] d;
    forever begin
      @(posedge mclk iff line_in === 1'b0);
      repeat (8) @(posedge mclk);
      if (line_in === 1'b0) begin
        d = 9'h000;
        for (int i = 0; i < nbits; i++) begin
          repeat (16) @(posedge mclk);
          d[i] = line_in;
        end
        repeat (16) @(posedge mclk);
        if (line_in === 1'b1) rxq.push_back(d);
      end
    end
  end
endmodule
`default_nettype wire

// file: tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import usart_pkg::*;
  logic mclk, rstn, tx, rx, ck_in, ck_out, ck_oe, tx_irq, rx_irq;
  apb_req_t req;
  apb_rsp_t rsp;
  int err_count = 0;
  int compares = 0;
  int cycles = 0;
  usart_core i_usart_core (.mclk(mclk), .rstn(rstn), .apb_req(req), .apb_rsp(rsp),
    .serial_rx_pin(rx), .serial_tx_pin(tx), .serial_clock_pin(ck_in),
    .serial_clock_out(ck_out), .serial_clock_oe(ck_oe), .tx_irq(tx_irq), .rx_irq(rx_irq));
  usart_partner i_usart_partner (.mclk(mclk), .line_in(tx), .line_out(rx), .clk_out(ck_in));
  // Free running clock.
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // A hang is cut short well beyond the expected run length.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 30000) begin
      err_count++;
      test_done();
    end
  end
  task automatic test_done;
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // One bus transfer; the error response is predicted from the address map.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    req.psel <= 1'b1;
    req.pwrite <= w;
    req.paddr <= a;
    req.pwdata <= wd;
    @(posedge mclk);
    req.penable <= 1'b1;
    // Waits for the slave as long as it takes; only the bench timeout ends a hang.
    do begin
      @(posedge mclk);
    end while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    chk({31'h0, rsp.pslverr}, {31'h0, a[1:0] != 2'b00 || a > 8'h1c}, "bus error");
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    apb(1'b1, a, {24'h0, d}, r);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                     input string s);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    chk(r & m, e, s);
  endtask
  task automatic take(input logic [8:0] e);
    logic [8:0] g;
    int n;
    n = 0;
    g = 'x;
    while (i_usart_partner.rxq.size() == 0 && n < 400) begin
      @(posedge mclk);
      n++;
    end
    if (i_usart_partner.rxq.size() > 0) g = i_usart_partner.rxq.pop_front();
    chk({23'h0, g}, {23'h0, e}, "line frame");
  endtask
  // Main sequence; the model predicts every frame, each status and buffer readback, and the generator rate from the settings.
  initial begin
    logic [7:0] fmts[9] = '{8'h00, 8'h08, 8'h10, 8'h30, 8'h80, 8'ha0, 8'hc0, 8'he0, 8'h88};
    logic [7:0] pc[6] = '{8'h08, 8'h10, 8'hf8, 8'h08, 8'h09, 8'h00};
    logic [7:0] dl[6] = '{8'h00, 8'h00, 8'h00, 8'h03, 8'h00, 8'h00};
    logic [8:0] w;
    logic [7:0] cfg, d, d2;
    logic [31:0] m;
    int nb, pb, t, e;
    logic v;
    logic n9;
    req = '0;
    n9 = 1'b0;
    rstn = 1'b0;
    void'($urandom(8510));
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    rdc(OFF_MAIN, 32'hff, 32'h01, "main reset");
    rdc(OFF_RXCTL, 32'hff, 32'h00, "rx status reset");
    rdc(OFF_PRESC, 32'hff, 32'h00, "prescaler reset");
    rdc(8'h20, 32'hffffffff, 32'h0, "unmapped");
    rdc(8'h06, 32'hffffffff, 32'h0, "unaligned");
    wr(OFF_IRQCLK, 8'h23);
    repeat (2) @(posedge mclk);
    chk(tx_irq, 1, "tx irq pending");
    d = $urandom;
    wr(OFF_TXBUF, d);
    @(posedge mclk);
    chk(tx_irq, 0, "tx irq removed");
    rdc(OFF_TXBUF, 32'hff, {24'h0, d}, "tx buffer readback");
    rdc(OFF_MAIN, 32'h01, 32'h0, "empty cleared");
    wr(OFF_PRESC, 8'h08);
    take({1'b0, d});
    for (int f = 0; f < 9; f++) begin
      cfg = fmts[f];
      d = $urandom;
      nb = cfg[3] ? 7 : (cfg[4] ? 9 : 8);
      pb = (cfg[7] && !cfg[4]) ? 1 : 0;
      // The received ninth bit keeps its value until the next nine-bit frame.
      if (nb == 9) begin
        n9 = cfg[5];
      end
      w = {cfg[5], d} & 9'((1 << nb) - 1);
      if (pb == 1) w[nb] = (cfg[6:5] == 2'b00) ? ~^w : (cfg[6:5] == 2'b01) ? ^w : ~cfg[5];
      m = (nb == 7) ? 32'h7f : 32'hff;
      i_usart_partner.nbits = nb + pb;
      wr(OFF_MAIN, cfg);
      wr(OFF_TXBUF, d);
      rdc(OFF_RXCTL, 32'h02, 32'h02, "active in frame");
      take(w);
      i_usart_partner.send(w, nb + pb, 1'b1);
      @(posedge mclk);
      chk(rx_irq, 1, "rx irq pending");
      rdc(OFF_MAIN, 32'h06, 32'h02, "rx full");
      rdc(OFF_RXBUF, m, {24'h0, d} & m, "rx char");
      rdc(OFF_RXCTL, 32'hea, {28'h0, n9, 3'b0}, "rx status");
      rdc(OFF_MAIN, 32'h02, 32'h0, "full cleared");
      chk(rx_irq, 0, "rx irq removed");
    end
    wr(OFF_MAIN, 8'h00);
    // Two stops, the last one short: the next start comes ten bits plus 14 ticks later.
    // The bench sees a new start one edge after its launch, hence the extra cycle.
    wr(OFF_IRQCLK, 8'he3);
    i_usart_partner.nbits = 8;
    d = $urandom;
    d2 = $urandom;
    wr(OFF_TXBUF, d);
    t = 32'($time);
    wr(OFF_TXBUF, d2);
    rdc(OFF_MAIN, 32'h01, 32'h0, "second byte held");
    take({1'b0, d});
    @(posedge mclk iff tx === 1'b0);
    chk(32'($time - t), 32'((16 * 10 + 14 + 1) * 50), "short last stop");
    take({1'b0, d2});
    wr(OFF_IRQCLK, 8'h23);
    i_usart_partner.send(9'h0a5, 8, 1'b0);
    rdc(OFF_MAIN, 32'h06, 32'h06, "framing error");
    rdc(OFF_RXCTL, 32'h41, 32'h40, "break gone");
    rdc(OFF_RXBUF, 32'hff, 32'ha5, "errored char");
    d = $urandom;
    wr(OFF_MAIN, 8'h38);
    wr(OFF_TXBUF, d);
    t = 0;
    while (rx_irq !== 1'b1 && t < 400) begin
      @(posedge mclk);
      t++;
    end
    chk(rx_irq, 1, "looped char arrived");
    chk(i_usart_partner.rxq.size(), 0, "line quiet");
    rdc(OFF_RXBUF, 32'hff, {24'h0, d}, "looped char");
    rdc(OFF_RXCTL, 32'h08, 32'h08, "looped ninth");
    // Same loop in synchronous mode, with the generator clock driven onto the clock pin.
    wr(OFF_IRQCLK, 8'h33);
    wr(OFF_PINCTL, 8'h01);
    chk(ck_oe, 1, "clock pin driven");
    d = $urandom;
    wr(OFF_TXBUF, d);
    t = 0;
    while (rx_irq !== 1'b1 && t < 400) begin
      @(posedge mclk);
      t++;
    end
    chk(rx_irq, 1, "sync char arrived");
    rdc(OFF_RXBUF, 32'hff, {24'h0, d}, "sync looped char");
    wr(OFF_PINCTL, 8'h00);
    chk(ck_oe, 0, "clock pin released");
    wr(OFF_IRQCLK, 8'h23);
    wr(OFF_MAIN, 8'h00);
    for (int k = 0; k < 6; k++) begin
      wr(OFF_PRESC, 8'h00);
      wr(OFF_DIVLO, dl[k]);
      wr(OFF_PRESC, pc[k]);
      e = (pc[k][7:3] == 0) ? 0 : 600 / ((pc[k][7:3] + 1) * ({pc[k][2:0], dl[k]} + 1));
      t = 0;
      v = ck_out;
      repeat (300) begin
        @(posedge mclk);
        if (ck_out !== v) t++;
        v = ck_out;
      end
      chk(t + 1 >= e && t <= e + 1, 1, "generator rate");
    end
    test_done();
  end
endmodule
`default_nettype wire
